// File: design/ccs_top.sv
// charge cycle sequencer: phase selection, termination, top-off and
// safety timers, temperature bands, shipping switch-off, apb registers
// assumes analog comparator levels arrive asynchronous to clk_sys
//
// Overview of operation
// - phase chosen from battery voltage throughout the charge
// - dpm or thermal regulation: no termination, slow timer
// - terminate on voltage and current, open switch
// - termination sets status 11 and interrupts
// - top-off timer follows safety timer pause, slowdown
// - top-off running flag readable with phase
// - top-off reset on enable, termination, restore
// - top-off length latched at termination
// - interrupt at top-off start and expiry
// - charge only inside thermistor window, else suspend
// - warm voltage select, cool current select
// - no termination in cool or warm band
// - boost thermistor fault suspends boost, status 000
// - safety limit 2 hours low, 10 hours above
// - safety expiry sets fault 11, interrupts
// - timer length programmable, timer can be disabled
// - half rate in regulation unless slowdown disabled
// - timer paused in fault, reset on restart
// - minimum system regulation flag
// - input voltage and current limit flags
// - battery switch off now or delayed
// - phase codes 00 off 01 pre 10 fast 11 done
// - each event a low 256 us pulse
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "ccs_consts.svh"

module ccs_top #(
  parameter logic [31:0] MINUTE_CYCLES = `CCS_MINUTE_S * `CCS_CLK_HZ,
  parameter logic [31:0] SHIP_CYCLES   = `CCS_SHIP_DLY_S * `CCS_CLK_HZ
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire ccs_pkg::ccs_sense_t sense,
  output ccs_pkg::ccs_drive_t     drive,
  output logic                    int_n
);

  // ---------------------------------------------------------------
  // constants and state
  // ---------------------------------------------------------------
  localparam int INT_CYC = (`CCS_INT_PULSE_NS + `CCS_CLK_NS - 1)
                           / `CCS_CLK_NS;
  localparam logic [11:0] INT_LEN = 12'(INT_CYC);

  ccs_pkg::ccs_state_t s_q;
  ccs_pkg::ccs_state_t s_d;

  assign pready  = 1'b1;
  assign prdata  = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign drive   = s_q.drv;
  assign int_n   = (s_q.int_cnt == 12'h000);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    ccs_pkg::ccs_sense_t sn;
    logic                en;
    logic                tick;
    logic                pause;
    logic                slow;
    logic                adv;
    logic                term_ok;
    logic                ev;
    logic                bfault;
    logic [9:0]          limit;
    logic [31:0]         rd;
    logic                setup;
    sn      = s_q.s2;
    en      = 1'b0;
    tick    = 1'b0;
    pause   = 1'b0;
    slow    = 1'b0;
    adv     = 1'b0;
    term_ok = 1'b0;
    ev      = 1'b0;
    bfault  = 1'b0;
    limit   = 10'h000;
    rd      = 32'h0000_0000;
    setup   = psel & ~penable;
    s_d     = s_q;

    // pins are asynchronous: two stages before any use
    s_d.s1 = sense;
    s_d.s2 = s_q.s1;

    // apb write; restore reloads defaults and leaves no trace
    if (psel && penable && pwrite && paddr == `CCS_ADDR_CTRL)
    begin
      if (pwdata[`CCS_C_RESTORE])
        s_d.ctrl = `CCS_CTRL_RST;
      else
        s_d.ctrl = pwdata[10:0];
    end

    // minute prescaler shared by both timers
    if (s_q.presc == MINUTE_CYCLES - 32'h1)
    begin
      s_d.presc = 32'h0;
      tick      = 1'b1;
    end
    else
      s_d.presc = s_q.presc + 32'h1;

    en = s_q.ctrl[`CCS_C_CHG_EN] & ~sn.ce_n & sn.conv_on
         & ~s_q.ctrl[`CCS_C_SW_OFF];
    s_d.en = en;
    pause  = ~sn.ts_in_win;
    slow   = s_q.ctrl[`CCS_C_SLOW_EN]
             & (sn.vdpm | sn.idpm | sn.ts_cool | sn.therm_reg);
    if (tick && !pause && slow)
      s_d.half = ~s_q.half;
    adv = tick & ~pause & (~slow | s_q.half);

    if (sn.vbat_lt_lowv)
      limit = `CCS_LIM_LOWV_MIN;
    else if (s_q.ctrl[`CCS_C_TMR_LEN])
      limit = `CCS_LIM_LONG_MIN;
    else
      limit = `CCS_LIM_SHORT_MIN;

    // termination blocked by regulation, bands or host choice
    term_ok = sn.vbat_gt_rechg & sn.ichg_lt_term
              & s_q.ctrl[`CCS_C_TERM_EN]
              & ~sn.vdpm & ~sn.idpm & ~sn.therm_reg
              & ~sn.ts_cool & ~sn.ts_warm & sn.ts_in_win;

    // ---------------------------------------------------------------
    // charge cycle
    // ---------------------------------------------------------------
    case (s_q.chg)
      ccs_pkg::CCS_OFF:
      begin
        s_d.phase    = `CCS_PH_OFF;
        s_d.safe_min = 10'h000;
        s_d.top_min  = 10'h000;
        s_d.half     = 1'b0;
        if (en && sn.ts_in_win)
          s_d.chg = ccs_pkg::CCS_CHG;
      end
      ccs_pkg::CCS_CHG:
      begin
        if (sn.vbat_lt_pre)
          s_d.phase = `CCS_PH_PRE;
        else
          s_d.phase = `CCS_PH_FAST;
        if (adv)
          s_d.safe_min = s_q.safe_min + 10'h001;
        if (s_q.ctrl[`CCS_C_TMR_EN] && s_q.safe_min >= limit)
        begin
          s_d.chg   = ccs_pkg::CCS_TFAULT;
          s_d.fault = `CCS_FLT_TIMER;
          ev        = 1'b1;
        end
        else if (term_ok)
        begin
          s_d.phase   = `CCS_PH_DONE;
          s_d.top_min = 10'h000;
          s_d.top_len = 10'(s_q.ctrl[`CCS_C_TOP_HI:`CCS_C_TOP_LO])
                        * `CCS_TOP_STEP_MIN;
          ev          = 1'b1;
          if (s_q.ctrl[`CCS_C_TOP_HI:`CCS_C_TOP_LO] != 2'h0)
            s_d.chg = ccs_pkg::CCS_TOPOFF;
          else
            s_d.chg = ccs_pkg::CCS_DONE;
        end
      end
      ccs_pkg::CCS_TOPOFF:
      begin
        if (adv)
          s_d.top_min = s_q.top_min + 10'h001;
        if (s_q.top_min >= s_q.top_len)
        begin
          s_d.chg = ccs_pkg::CCS_DONE;
          ev      = 1'b1;
        end
      end
      ccs_pkg::CCS_DONE:
      begin
        // recharge starts a fresh cycle with a fresh top-off length
        if (!sn.vbat_gt_rechg)
        begin
          s_d.chg      = ccs_pkg::CCS_CHG;
          s_d.safe_min = 10'h000;
        end
      end
      ccs_pkg::CCS_TFAULT:
        s_d.fault = `CCS_FLT_TIMER;
      default:
        s_d.chg = ccs_pkg::CCS_OFF;
    endcase
    // disable wins over any state; restart clears timers and fault
    if (!en)
    begin
      s_d.chg   = ccs_pkg::CCS_OFF;
      s_d.fault = 2'h0;
    end
    if (psel && penable && pwrite && paddr == `CCS_ADDR_CTRL
        && pwdata[`CCS_C_RESTORE])
      s_d.top_min = 10'h000;

    // ---------------------------------------------------------------
    // interrupt pulse; an event during a pulse is held, not lost
    // ---------------------------------------------------------------
    bfault = sn.boost_mode & ~sn.ts_in_boost_win;
    // last cycle's fault level is the registered suspend drive
    if (bfault && !s_q.drv.boost_suspend)
      ev = 1'b1;
    if (s_q.int_cnt != 12'h000)
    begin
      s_d.int_cnt = s_q.int_cnt - 12'h001;
      if (ev)
        s_d.int_pend = 1'b1;
    end
    else if (ev || s_q.int_pend)
    begin
      s_d.int_cnt  = INT_LEN;
      s_d.int_pend = 1'b0;
    end

    // ---------------------------------------------------------------
    // shipping switch-off
    // ---------------------------------------------------------------
    if (!s_q.ctrl[`CCS_C_SW_OFF])
    begin
      s_d.ship_cnt  = 32'h0;
      s_d.ship_open = 1'b0;
    end
    else if (!s_q.ctrl[`CCS_C_SW_DLY])
      s_d.ship_open = 1'b1;
    else if (s_q.ship_cnt >= SHIP_CYCLES - 32'h1)
      s_d.ship_open = 1'b1;
    else
      s_d.ship_cnt = s_q.ship_cnt + 32'h1;

    // ---------------------------------------------------------------
    // drive toward the power stage
    // ---------------------------------------------------------------
    s_d.drv.chg_on = (s_q.chg == ccs_pkg::CCS_CHG
                      || s_q.chg == ccs_pkg::CCS_TOPOFF)
                     && sn.ts_in_win;
    if (sn.vbat_lt_short)
      s_d.drv.cur_sel = 2'h1;
    else if (sn.vbat_lt_pre)
      s_d.drv.cur_sel = 2'h2;
    else
      s_d.drv.cur_sel = 2'h3;
    if (!sn.ts_cool)
      s_d.drv.cool_sel = 2'h0;
    else if (s_q.ctrl[`CCS_C_COOL_SEL])
      s_d.drv.cool_sel = 2'h2;
    else
      s_d.drv.cool_sel = 2'h1;
    s_d.drv.vreg_4v1 = sn.ts_warm & s_q.ctrl[`CCS_C_WARM_SEL];
    s_d.drv.boost_suspend  = bfault;
    s_d.drv.batt_switch_on = ~s_q.ship_open
                             & (s_q.chg != ccs_pkg::CCS_DONE);

    // ---------------------------------------------------------------
    // apb read data, captured in the setup cycle
    // ---------------------------------------------------------------
    rd[1:0]                 = s_q.phase;
    rd[`CCS_S_TOP_RUN]      = (s_q.chg == ccs_pkg::CCS_TOPOFF);
    rd[`CCS_S_FAULT_LO+:2]  = s_q.fault;
    if (bfault)
      rd[`CCS_S_SRC_LO+:3]  = `CCS_SRC_NONE;
    else if (sn.boost_mode)
      rd[`CCS_S_SRC_LO+:3]  = `CCS_SRC_BOOST;
    else
      rd[`CCS_S_SRC_LO+:3]  = sn.vbus_type;
    rd[`CCS_S_NTC]          = bfault;
    rd[`CCS_S_VLIM]         = sn.vdpm;
    rd[`CCS_S_ILIM]         = sn.idpm;
    rd[`CCS_S_MINSYS]       = sn.sys_at_min;
    rd[`CCS_S_THREG]        = sn.therm_reg;
    if (setup)
    begin
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (paddr == `CCS_ADDR_CTRL)
        s_d.prdata = {21'h0, s_q.ctrl};
      else if (paddr == `CCS_ADDR_STATUS)
        s_d.prdata = pwrite ? 32'h0000_0000 : rd;
      else
        s_d.pslverr = 1'b1;
      if (pwrite && paddr == `CCS_ADDR_STATUS)
        s_d.pslverr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_q      <= '0;
      s_q.ctrl <= `CCS_CTRL_RST;
      s_q.chg  <= ccs_pkg::CCS_OFF;
    end
    else
      s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [11:0] low_len_q;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn || int_n)
      low_len_q <= 12'h000;
    else
      low_len_q <= low_len_q + 12'h001;
  end

  chk_int_width: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(int_n) |-> low_len_q == INT_LEN)
    else $error("interrupt pulse length wrong");

  chk_term_status: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.chg == ccs_pkg::CCS_CHG && s_d.chg == ccs_pkg::CCS_DONE && s_q.en)
    |=> s_q.phase == `CCS_PH_DONE && (!int_n || s_q.int_pend))
    else $error("termination status or pulse missing");

  chk_term_block: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.chg == ccs_pkg::CCS_CHG && (s_q.s2.vdpm || s_q.s2.ts_cool
     || s_q.s2.ts_warm || s_q.s2.therm_reg || s_q.s2.idpm))
    |=> s_q.chg != ccs_pkg::CCS_DONE && s_q.chg != ccs_pkg::CCS_TOPOFF)
    else $error("termination during regulation or band");

  chk_timer_fault: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(s_q.chg == ccs_pkg::CCS_TFAULT)
    |-> s_q.fault == `CCS_FLT_TIMER && (!int_n || s_q.int_pend))
    else $error("safety expiry not reported");

  chk_pend_fire: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (int_n && s_q.int_pend) |=> !int_n)
    else $error("queued interrupt pulse not sent");

  chk_timer_off: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.chg == ccs_pkg::CCS_CHG && !s_q.ctrl[`CCS_C_TMR_EN])
    |=> s_q.chg != ccs_pkg::CCS_TFAULT)
    else $error("disabled safety timer expired");

  chk_restart_clear: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.chg == ccs_pkg::CCS_OFF && s_d.chg == ccs_pkg::CCS_CHG)
    |=> s_q.safe_min == 10'h000 && s_q.fault == 2'h0)
    else $error("safety timer not reset on restart");

  chk_ship_now: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ($rose(s_q.ctrl[`CCS_C_SW_OFF]) && !s_q.ctrl[`CCS_C_SW_DLY])
    |-> ##2 !drive.batt_switch_on)
    else $error("battery switch not opened at once");

  chk_boost_fault: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.s2.boost_mode && !s_q.s2.ts_in_boost_win)
    |=> drive.boost_suspend)
    else $error("boost not suspended on thermistor fault");

  chk_topoff_latch: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.chg == ccs_pkg::CCS_TOPOFF && s_d.chg == ccs_pkg::CCS_TOPOFF)
    |=> $stable(s_q.top_len))
    else $error("top-off length changed while running");

endmodule

// File: inc/ccs_consts.svh
// register offsets, field positions, reset values and timing figures
// of the charge cycle sequencer; included by the top and the bench
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// ---------------------------------------------------------------
// register map (byte addresses on apb)
// ---------------------------------------------------------------
`define CCS_ADDR_CTRL     8'h00
`define CCS_ADDR_STATUS   8'h04
// control fields
`define CCS_C_CHG_EN      0
`define CCS_C_TERM_EN     1
`define CCS_C_TMR_EN      2
`define CCS_C_SLOW_EN     3
`define CCS_C_TMR_LEN     4
`define CCS_C_TOP_LO      5
`define CCS_C_TOP_HI      6
`define CCS_C_WARM_SEL    7
`define CCS_C_COOL_SEL    8
`define CCS_C_SW_OFF      9
`define CCS_C_SW_DLY      10
`define CCS_C_RESTORE     11
`define CCS_CTRL_RST      11'h01f
// status fields
`define CCS_S_TOP_RUN     2
`define CCS_S_FAULT_LO    3
`define CCS_S_SRC_LO      5
`define CCS_S_NTC         8
`define CCS_S_VLIM        9
`define CCS_S_ILIM        10
`define CCS_S_MINSYS      11
`define CCS_S_THREG       12

// ---------------------------------------------------------------
// encodings
// ---------------------------------------------------------------
`define CCS_PH_OFF        2'h0
`define CCS_PH_PRE        2'h1
`define CCS_PH_FAST       2'h2
`define CCS_PH_DONE       2'h3
`define CCS_FLT_TIMER     2'h3
`define CCS_SRC_BOOST     3'h7
`define CCS_SRC_NONE      3'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CCS_CLK_NS        100
`define CCS_CLK_HZ        10000000
`define CCS_INT_PULSE_NS  256000
`define CCS_MINUTE_S      60
`define CCS_SHIP_DLY_S    10
`define CCS_LIM_LOWV_MIN  10'd120
`define CCS_LIM_SHORT_MIN 10'd300
`define CCS_LIM_LONG_MIN  10'd600
`define CCS_TOP_STEP_MIN  10'd15

`endif

// File: inc/ccs_pkg.sv
// types of the charge cycle sequencer: sensed levels, drive outputs,
// charge states and the whole register state of the top module
package ccs_pkg;

  // comparator and pin levels coming from the analog side
  typedef struct packed {
    logic       ce_n;
    logic       conv_on;
    logic       vbat_lt_short;
    logic       vbat_lt_pre;
    logic       vbat_lt_lowv;
    logic       vbat_gt_rechg;
    logic       ichg_lt_term;
    logic       vdpm;
    logic       idpm;
    logic       therm_reg;
    logic       ts_in_win;
    logic       ts_cool;
    logic       ts_warm;
    logic       ts_in_boost_win;
    logic       boost_mode;
    logic       sys_at_min;
    logic [2:0] vbus_type;
  } ccs_sense_t;

  // levels driven toward the analog side
  typedef struct packed {
    logic       chg_on;
    logic [1:0] cur_sel;
    logic [1:0] cool_sel;
    logic       vreg_4v1;
    logic       boost_suspend;
    logic       batt_switch_on;
  } ccs_drive_t;

  typedef enum logic [2:0] {
    CCS_OFF,
    CCS_CHG,
    CCS_TOPOFF,
    CCS_DONE,
    CCS_TFAULT
  } ccs_chg_t;

  typedef struct packed {
    ccs_sense_t  s1;
    ccs_sense_t  s2;
    logic [10:0] ctrl;
    ccs_chg_t    chg;
    logic        en;
    logic [1:0]  phase;
    logic [1:0]  fault;
    logic [31:0] presc;
    logic        half;
    logic [9:0]  safe_min;
    logic [9:0]  top_min;
    logic [9:0]  top_len;
    logic [11:0] int_cnt;
    logic        int_pend;
    logic [31:0] ship_cnt;
    logic        ship_open;
    logic [31:0] prdata;
    logic        pslverr;
    ccs_drive_t  drv;
  } ccs_state_t;

endpackage

// File: testbench/ccs_host.sv
// apb master standing in for the host processor of the sequencer
// assumes pready, prdata and pslverr are sampled at rising clk_sys edges
`timescale 1ns/100ps
module ccs_host (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ----------------------------------------------------------
  // one transfer: setup, access until pready, then release
  // ----------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines flip so a stale value is never taken for valid
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench of the charge cycle sequencer
// assumes ccs_host as register master and shortened timer parameters
`timescale 1ns/100ps
`include "ccs_consts.svh"
module tb_top;
  logic                clk_sys;
  logic                resetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  ccs_pkg::ccs_sense_t sense;
  ccs_pkg::ccs_drive_t drive;
  logic                int_n;
  int                  bad_count;
  int                  checks_done;
  int                  cyc = 0;
  logic [31:0]         st;
  logic                er;

  // one timer minute is 20 cycles, the switch-off delay 50 cycles
  ccs_top #(.MINUTE_CYCLES(32'h14), .SHIP_CYCLES(32'h32)) i_ccs_top (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .drive(drive),
    .int_n(int_n));
  ccs_host i_ccs_host (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_ccs_host.xfer(1'b1, a, d, st, er);
  endtask
  task rd(input logic [7:0] a);
    i_ccs_host.xfer(1'b0, a, 32'h0, st, er);
  endtask
  task rs();
    rd(`CCS_ADDR_STATUS);
  endtask
  // bounded wait for a level on the interrupt line
  task wait_int(input logic v, input int max);
    int n;
    n = 0;
    while (int_n !== v && n < max)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(int_n, v);
  endtask
  // reset held 5 cycles; sensed levels of a healthy charging cell
  task restart();
    ccs_pkg::ccs_sense_t s;
    s = '0;
    s.conv_on = 1'b1;
    s.ts_in_win = 1'b1;
    s.ts_in_boost_win = 1'b1;
    @(posedge clk_sys);
    resetn <= 1'b0;
    sense <= s;
    step(5);
    resetn <= 1'b1;
    step(4);
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task s_regs();
    restart();
    rd(`CCS_ADDR_CTRL);
    chk(st, 32'h0000001f);
    wr(8'h08, 32'h1);
    chk(er, 1'b1);
    wr(`CCS_ADDR_STATUS, 32'h0);
    chk(er, 1'b1);
    wr(`CCS_ADDR_CTRL, 32'h1e0);
    rd(`CCS_ADDR_CTRL);
    chk(st, 32'h000001e0);
    step(6);
    rs();
    chk(st[1:0], 2'h0);
  endtask

  task s_phase();
    restart();
    for (int i = 0; i < 3; i++)
    begin
      sense.vbat_lt_short <= (i == 0);
      sense.vbat_lt_pre   <= (i < 2);
      step(6);
      rs();
      chk(st[1:0], (i < 2) ? 2'h1 : 2'h2);
      chk(drive.cur_sel, i + 1);
    end
  endtask

  task s_term();
    int n;
    restart();
    sense.vbat_gt_rechg <= 1'b1;
    sense.ichg_lt_term  <= 1'b1;
    sense.vdpm          <= 1'b1;
    step(20);
    rs();
    chk(st[1:0], 2'h2);
    chk(st[9], 1'b1);
    sense.vdpm <= 1'b0;
    sense.idpm <= 1'b1;
    step(20);
    rs();
    chk(st[1:0], 2'h2);
    chk(st[10], 1'b1);
    sense.idpm      <= 1'b0;
    sense.therm_reg <= 1'b1;
    step(20);
    rs();
    chk(st[1:0], 2'h2);
    chk(st[12], 1'b1);
    sense.therm_reg <= 1'b0;
    sense.ts_cool   <= 1'b1;
    wr(`CCS_ADDR_CTRL, 32'h11f);
    step(20);
    rs();
    chk(st[1:0], 2'h2);
    chk(drive.cool_sel, 2'h2);
    // termination off before the band ends, else it fires at once
    wr(`CCS_ADDR_CTRL, 32'h01d);
    sense.ts_cool <= 1'b0;
    step(20);
    rs();
    chk(st[1:0], 2'h2);
    wr(`CCS_ADDR_CTRL, 32'h01f);
    wait_int(1'b0, 30);
    n = 0;
    while (int_n === 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(n, 2560);
    rs();
    chk(st[2:0], 3'h3);
    chk(drive.batt_switch_on, 1'b0);
  endtask

  // top-off of 15 minutes; a longer length written later is ignored
  task s_topoff();
    restart();
    wr(`CCS_ADDR_CTRL, 32'h03f);
    sense.vbat_gt_rechg <= 1'b1;
    sense.ichg_lt_term  <= 1'b1;
    wait_int(1'b0, 30);
    rs();
    chk(st[2:0], 3'h7);
    wr(`CCS_ADDR_CTRL, 32'h07f);
    step(200);
    rs();
    chk(st[2], 1'b1);
    step(150);
    rs();
    chk(st[2], 1'b0);
    wait_int(1'b1, 2600);
    wait_int(1'b0, 5);
  endtask

  // low cell, slowed, slowdown off, timer off, 5 hour length
  task s_safety();
    int          lo [5] = '{2300, 4600, 2300, 2300, 5900};
    logic [11:0] ctl [5] = '{12'h01f, 12'h01f, 12'h017, 12'h01b, 12'h00f};
    for (int i = 0; i < 5; i++)
    begin
      restart();
      sense.vbat_lt_lowv <= (i != 4);
      sense.vdpm         <= (i == 1 || i == 2);
      wr(`CCS_ADDR_CTRL, {20'h0, ctl[i]});
      step(lo[i]);
      rs();
      chk(st[4:3], 2'h0);
      step(300);
      rs();
      chk(st[4:3], (i == 3) ? 2'h0 : 2'h3);
      chk(int_n, i == 3);
    end
  endtask

  task s_band();
    restart();
    sense.ts_warm    <= 1'b1;
    sense.sys_at_min <= 1'b1;
    wr(`CCS_ADDR_CTRL, 32'h09f);
    step(6);
    chk(drive.vreg_4v1, 1'b1);
    rs();
    chk(st[11], 1'b1);
    sense.ts_in_win <= 1'b0;
    step(6);
    chk(drive.chg_on, 1'b0);
    sense.ts_in_win <= 1'b1;
    step(6);
    chk(drive.chg_on, 1'b1);
    sense.boost_mode      <= 1'b1;
    sense.ts_in_boost_win <= 1'b0;
    step(6);
    chk(int_n, 1'b0);
    rs();
    chk(st[8:5], 4'h8);
    chk(drive.boost_suspend, 1'b1);
    sense.ts_in_boost_win <= 1'b1;
    step(6);
    rs();
    chk(st[8:5], 4'h7);
  endtask

  task s_ship();
    restart();
    wr(`CCS_ADDR_CTRL, 32'h21f);
    step(5);
    chk(drive.batt_switch_on, 1'b0);
    restart();
    step(4);
    chk(drive.batt_switch_on, 1'b1);
    wr(`CCS_ADDR_CTRL, 32'h61f);
    step(20);
    chk(drive.batt_switch_on, 1'b1);
    step(50);
    chk(drive.batt_switch_on, 1'b0);
  endtask

  // ----------------------------------------------------------
  // verdict, main sequence and hang guard
  // ----------------------------------------------------------
  task report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    resetn = 1'b0;
    sense = '0;
    bad_count = 0;
    checks_done = 0;
    s_regs();
    s_phase();
    s_term();
    s_topoff();
    s_safety();
    s_band();
    s_ship();
    report_and_stop();
  end

  // the full run needs about 25000 cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
endmodule
